// ### sps_master_model.sv
// Behavioural bus master for the single-pin serial slave
`timescale 1ns/1ps

module sps_master_model #(
  parameter int TE = 40,
  parameter int STBY = 200,
  parameter int HDR = 60,
  parameter int TSS = 80
) (
  // Clock
  input wire logic clk_sys,
  // Shared pin
  input wire logic line,
  input wire logic slave_oe,
  output logic mst_low
);
  // ----------------------------------------
  // Line control
  // ----------------------------------------
  initial mst_low = 1'b0;

  task automatic half(input logic v);
    mst_low <= ~v;
    repeat (TE / 2) @(posedge clk_sys);
  endtask : half

  task automatic bit_out(input logic b);
    half(~b);
    half(b);
  endtask : bit_out

  // ----------------------------------------
  // Byte with acknowledge sequence
  // ----------------------------------------
  task automatic byte_out(input logic [7:0] b, input logic mack, output logic slave_ack);
    logic s1;
    logic s2;
    for (int i = 7; i >= 0; i--)
    begin
      bit_out(b[i]);
    end
    bit_out(mack);
    mst_low <= 1'b0;
    repeat (TE / 4) @(posedge clk_sys);
    #1 s1 = line;
    repeat (TE / 2) @(posedge clk_sys);
    #1 s2 = line;
    repeat (TE / 4) @(posedge clk_sys);
    slave_ack = (s1 === 1'b0) && (s2 === 1'b1);
  endtask : byte_out

  task automatic standby();
    @(posedge clk_sys);
    while (slave_oe === 1'b1) @(posedge clk_sys);
    mst_low <= 1'b0;
    repeat (STBY + 8) @(posedge clk_sys);
  endtask : standby

  task automatic header(output logic slave_ack);
    @(posedge clk_sys);
    mst_low <= 1'b1;
    repeat (HDR) @(posedge clk_sys);
    byte_out(8'h55, 1'b1, slave_ack);
  endtask : header

  task automatic gap();
    mst_low <= 1'b0;
    repeat (TSS) @(posedge clk_sys);
  endtask : gap
endmodule : sps_master_model

// ### sps_pkg.sv
// Shared constants and types for the single-pin serial slave front end
package sps_pkg;
  // ----------------------------------------
  // Clock and bus timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int STBY_TIME_US = 600;
  localparam int STBY_CYC = STBY_TIME_US * CLK_MHZ;
  localparam int TE_MIN_US = 10;
  localparam int TE_MAX_US = 100;
  localparam int TE_MIN_CYC = TE_MIN_US * CLK_MHZ;
  localparam int TE_MAX_CYC = TE_MAX_US * CLK_MHZ;
  localparam logic [15:0] TE_RESET = 16'(TE_MAX_CYC);
  // ----------------------------------------
  // Counter widths and header measurement
  // ----------------------------------------
  localparam int PH_W = 18;
  localparam int HI_W = 16;
  localparam logic [2:0] HDR_LAST_EDGE = 3'h4;
  localparam logic [2:0] HDR_BITS_DONE = 3'h5;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // ----------------------------------------
  // Data path
  // ----------------------------------------
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  typedef struct packed {
    logic is_cmd;
    logic [BYTE_W-1:0] data;
  } sps_byte_t;
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STBY = 3'b001,
    ST_HLOW = 3'b010,
    ST_MEAS = 3'b011,
    ST_BITS = 3'b100,
    ST_MACK = 3'b101,
    ST_SACK = 3'b110
  } sps_state_t;
  typedef enum logic [1:0] {
    SG_HDR = 2'b00,
    SG_ADDR = 2'b01,
    SG_CMD = 2'b10,
    SG_DATA = 2'b11
  } sps_stage_t;
endpackage : sps_pkg

// ### sps_slave.sv
// Single-pin Manchester bus slave front end with its receive FIFO
//
// What this block does
// - Bit rate 10 to 100 kHz is set by master; slave follows it.
// - Master edges within 0.06 UI; slave output edges within 0.25 UI.
// - Line high for 600 us resets bus logic into standby.
// - In standby, first falling edge wakes the slave for a header.
// - Header timing sets the slave bit period for the command.
// - Every byte is followed by master ack bit then slave ack bit.
// - Master one continues; master zero ends and starts writes.
// - No write start when ended before any data byte arrived.
// - Slave ack is a one; not-ack omits the mid-bit edge.
// - Header is always answered with slave not-ack.
// - Not-ack on bad address, bad command, lost sync, early end.
// - First byte is address: family code high, device code low.
// - Command byte kept in an 8-bit register; bits Manchester coded.
// - Standby entered after clean finish or standby pulse.
// - Idle after bad address, bad command or missed edge.
// - Each master ack one (rising mid-bit edge) retunes the slave time base.
`timescale 1ns/1ps

// ----------------------------------------
// Receive FIFO
// ----------------------------------------
module sps_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic wr;
  logic rd;

  assign in_ready = cnt != (AW + 1)'(D);
  assign out_valid = cnt != '0;
  assign out_data = mem[rp];
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (wr)
    begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end
    else
    begin
      if (wr)
      begin
        wp <= (wp == LAST) ? '0 : wp + 1'b1;
      end
      if (rd)
      begin
        rp <= (rp == LAST) ? '0 : rp + 1'b1;
      end
      if (wr && !rd)
      begin
        cnt <= cnt + 1'b1;
      end
      else if (rd && !wr)
      begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule : sps_fifo

// ----------------------------------------
// Slave front end
// ----------------------------------------
module sps_slave
  import sps_pkg::*;
#(
  parameter int STBY_CYCLES = STBY_CYC,
  // Identity codes, values arbitrary
  parameter logic [3:0] FAMILY_CODE = 4'h5,
  parameter logic [3:0] DEVICE_CODE = 4'h3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Shared serial pin
  input wire logic serial_clock_data_io_in,
  output logic serial_clock_data_io_out,
  output logic serial_clock_data_io_oe,
  // Received command and data bytes
  output logic rx_valid,
  output sps_byte_t rx_data,
  input wire logic rx_ready,
  // Command status
  input wire logic cmd_reject,
  output logic [BYTE_W-1:0] cmd_reg,
  output logic write_start,
  output logic cmd_done,
  output logic in_standby
);
  logic s1, s2, s3, lvl, lvl_d;
  logic rise, fall, edge_seen;
  logic [HI_W-1:0] hi_cnt;
  logic stby_hit;
  sps_state_t state, after;
  sps_stage_t stage;
  logic [PH_W-1:0] ph;
  logic [15:0] te;
  logic [PH_W-1:0] win_lo, win_hi, half, te_w;
  logic [2:0] ec, bitcnt;
  logic [BYTE_W-1:0] shreg;
  logic slave_ack, half2, push, fifo_ready;
  sps_byte_t push_data;
  logic [$bits(sps_byte_t)-1:0] fifo_out;
  logic mid_edge, master_ack;

  // ----------------------------------------
  // Pin synchroniser and edges
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      lvl <= 1'b0;
      lvl_d <= 1'b0;
    end
    else
    begin
      s1 <= serial_clock_data_io_in;
      s2 <= s1;
      s3 <= s2;
      lvl_d <= lvl;
      if (s2 == s3)
      begin
        lvl <= s3;
      end
    end
  end

  assign rise = lvl && !lvl_d;
  assign fall = !lvl && lvl_d;
  assign edge_seen = rise || fall;

  // ----------------------------------------
  // Standby pulse detector
  // ----------------------------------------
  assign stby_hit = lvl && (hi_cnt == HI_W'(STBY_CYCLES - 1));

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      hi_cnt <= '0;
    end
    else if (!lvl)
    begin
      hi_cnt <= '0;
    end
    else if (!stby_hit)
    begin
      hi_cnt <= hi_cnt + 1'b1;
    end
  end

  // ----------------------------------------
  // Bit timing window
  // ----------------------------------------
  assign te_w = PH_W'(te);
  assign win_lo = te_w - (te_w >> 2);
  assign win_hi = te_w + (te_w >> 2);
  assign half = te_w >> 1;
  assign mid_edge = edge_seen && (ph >= win_lo);
  assign master_ack = rise;

  // ----------------------------------------
  // Protocol sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      after <= ST_IDLE;
      stage <= SG_HDR;
      ph <= '0;
      te <= TE_RESET;
      ec <= '0;
      bitcnt <= '0;
      shreg <= '0;
      slave_ack <= 1'b0;
      half2 <= 1'b0;
      cmd_reg <= '0;
      write_start <= 1'b0;
      cmd_done <= 1'b0;
      push <= 1'b0;
      push_data <= '0;
    end
    else
    begin
      write_start <= 1'b0;
      cmd_done <= 1'b0;
      push <= 1'b0;
      if (stby_hit)
      begin
        state <= ST_STBY;
      end
      else
      begin
        unique case (state)
          ST_IDLE:
          begin
            state <= ST_IDLE;
          end
          ST_STBY:
          begin
            if (fall)
            begin
              state <= ST_HLOW;
            end
          end
          ST_HLOW:
          begin
            if (rise)
            begin
              state <= ST_MEAS;
              stage <= SG_HDR;
              ec <= '0;
              ph <= '0;
            end
          end
          ST_MEAS:
          begin
            if (edge_seen)
            begin
              ec <= ec + 1'b1;
              ph <= (ec == '0) ? '0 : ph + 1'b1;
              if (ec == HDR_LAST_EDGE)
              begin
                te <= 16'((ph + 1'b1) >> 2);
                ph <= '0;
                bitcnt <= HDR_BITS_DONE;
                state <= ST_BITS;
              end
            end
            else if (ph == '1)
            begin
              state <= ST_IDLE;
            end
            else
            begin
              ph <= ph + 1'b1;
            end
          end
          ST_BITS, ST_MACK:
          begin
            if (mid_edge)
            begin
              ph <= '0;
              if (state == ST_BITS)
              begin
                shreg <= {shreg[BYTE_W-2:0], rise};
                bitcnt <= bitcnt + 1'b1;
                if (bitcnt == BIT_LAST)
                begin
                  state <= ST_MACK;
                end
              end
              else
              begin
                state <= ST_SACK;
                half2 <= 1'b0;
                if (master_ack)
                begin
                  te <= 16'((ph + 1'b1 + te_w + (te_w << 1)) >> 2);
                end
                unique case (stage)
                  SG_HDR:
                  begin
                    slave_ack <= 1'b0;
                    after <= master_ack ? ST_BITS : ST_IDLE;
                    stage <= SG_ADDR;
                  end
                  SG_ADDR:
                  begin
                    if (shreg != {FAMILY_CODE, DEVICE_CODE})
                    begin
                      slave_ack <= 1'b0;
                      after <= ST_IDLE;
                    end
                    else
                    begin
                      slave_ack <= 1'b1;
                      after <= master_ack ? ST_BITS : ST_STBY;
                      cmd_done <= !master_ack;
                      stage <= SG_CMD;
                    end
                  end
                  SG_CMD:
                  begin
                    cmd_reg <= shreg;
                    if (!master_ack || cmd_reject || !fifo_ready)
                    begin
                      slave_ack <= 1'b0;
                      after <= ST_IDLE;
                    end
                    else
                    begin
                      slave_ack <= 1'b1;
                      push <= 1'b1;
                      push_data <= '{is_cmd: 1'b1, data: shreg};
                      after <= ST_BITS;
                      stage <= SG_DATA;
                    end
                  end
                  SG_DATA:
                  begin
                    if (!fifo_ready)
                    begin
                      slave_ack <= 1'b0;
                      after <= ST_IDLE;
                    end
                    else
                    begin
                      slave_ack <= 1'b1;
                      push <= 1'b1;
                      push_data <= '{is_cmd: 1'b0, data: shreg};
                      after <= master_ack ? ST_BITS : ST_STBY;
                      write_start <= !master_ack;
                      cmd_done <= !master_ack;
                    end
                  end
                endcase
              end
            end
            else if (ph > win_hi)
            begin
              state <= ST_IDLE;
            end
            else
            begin
              ph <= ph + 1'b1;
            end
          end
          ST_SACK:
          begin
            ph <= ph + 1'b1;
            if (!half2 && ph == te_w - 1'b1)
            begin
              ph <= '0;
              half2 <= 1'b1;
            end
            else if (half2 && ph == half - 1'b1)
            begin
              half2 <= 1'b0;
              state <= after;
              bitcnt <= '0;
            end
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Pin driver for the slave ack bit
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      serial_clock_data_io_oe <= 1'b0;
      serial_clock_data_io_out <= 1'b0;
    end
    else
    begin
      serial_clock_data_io_oe <= !stby_hit && state == ST_SACK && slave_ack
        && (half2 ? (ph < half - 1'b1) : (ph >= half));
      serial_clock_data_io_out <= half2;
    end
  end

  assign in_standby = state == ST_STBY;

  // ----------------------------------------
  // Receive buffer
  // ----------------------------------------
  sps_fifo #(
    .W($bits(sps_byte_t)),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(push),
    .in_data(push_data),
    .in_ready(fifo_ready),
    .out_valid(rx_valid),
    .out_data(fifo_out),
    .out_ready(rx_ready)
  );

  assign rx_data = sps_byte_t'(fifo_out);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_stby_entry: assert property (stby_hit |=> state == ST_STBY)
    else $error("standby pulse did not reach standby");
  a_wake_fall: assert property (state == ST_STBY && fall && !stby_hit |=> state == ST_HLOW)
    else $error("standby did not wake on falling edge");
  a_hdr_slave_not_ack: assert property (state == ST_MACK && mid_edge && stage == SG_HDR |=> !slave_ack)
    else $error("header answered with slave ack");
  a_addr_miss: assert property (state == ST_MACK && mid_edge && stage == SG_ADDR
    && shreg != {FAMILY_CODE, DEVICE_CODE} && !stby_hit |=> !slave_ack && after == ST_IDLE)
    else $error("foreign address acknowledged");
  a_ack_shape: assert property ($rose(serial_clock_data_io_oe) |-> (!serial_clock_data_io_out)[*8])
    else $error("slave ack does not open low");
  a_drive_sak: assert property (serial_clock_data_io_oe |-> $past(slave_ack) && $past(state) == ST_SACK)
    else $error("pin driven outside slave ack");
  a_write_gate: assert property (write_start |-> $past(stage) == SG_DATA && push)
    else $error("write started without data byte");
  a_lost_sync: assert property (state == ST_BITS && !mid_edge && ph > win_hi && !stby_hit
    |=> state == ST_IDLE)
    else $error("missed edge not sent to idle");
  a_idle_deaf: assert property (state == ST_IDLE && !stby_hit |=> state == ST_IDLE)
    else $error("idle left without standby pulse");
endmodule : sps_slave

// ### sps_slave_tb_top.sv
// Self-checking testbench for the single-pin serial slave
`timescale 1ns/1ps

module sps_slave_tb_top
  import sps_pkg::*;
;
  localparam logic [7:0] ADDR = 8'h53;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic rx_ready = 1'b0;
  logic cmd_reject = 1'b0;
  logic sio_out;
  logic sio_oe;
  logic rx_valid;
  sps_byte_t rx_data;
  logic [BYTE_W-1:0] cmd_reg;
  logic write_start;
  logic cmd_done;
  logic in_standby;
  logic mst_low;
  logic line;
  logic s;
  int err_count = 0;
  int cmp_count = 0;
  int ws_n = 0;
  int cd_n = 0;

  always #10 clk_sys = ~clk_sys;
  assign line = ~(mst_low | (sio_oe & ~sio_out));

  sps_slave #(.STBY_CYCLES(200)) uut (
    .clk_sys(clk_sys), .rstn(rstn),
    .serial_clock_data_io_in(line), .serial_clock_data_io_out(sio_out), .serial_clock_data_io_oe(sio_oe),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .cmd_reject(cmd_reject), .cmd_reg(cmd_reg), .write_start(write_start),
    .cmd_done(cmd_done), .in_standby(in_standby)
  );

  sps_master_model #(.TE(40), .STBY(200), .HDR(60), .TSS(80)) m (
    .clk_sys(clk_sys), .line(line), .slave_oe(sio_oe), .mst_low(mst_low)
  );

  always @(posedge clk_sys)
  begin
    if (write_start === 1'b1) ws_n++;
    if (cmd_done === 1'b1) cd_n++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic c, input string msg);
    cmp_count++;
    if (c !== 1'b1)
    begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic pop(input sps_byte_t exp);
    @(negedge clk_sys);
    chk(rx_valid === 1'b1 && rx_data === exp, "fifo head wrong");
    @(posedge clk_sys);
    rx_ready <= 1'b1;
    @(posedge clk_sys);
    rx_ready <= 1'b0;
  endtask : pop

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    @(negedge clk_sys);
    chk(sio_oe === 1'b0 && rx_valid === 1'b0 && cmd_reg === 8'h00 && in_standby === 1'b0, "reset");
    m.header(s);
    m.byte_out(ADDR, 1'b1, s);
    chk(s === 1'b0 && in_standby === 1'b0, "idle answered");
    $display("t_reset finished");
  endtask : t_reset

  task automatic t_addr_only();
    m.standby();
    @(negedge clk_sys);
    chk(in_standby === 1'b1, "no standby");
    m.header(s);
    chk(s === 1'b0 && in_standby === 1'b0, "header ack");
    m.byte_out(ADDR, 1'b0, s);
    m.gap();
    @(negedge clk_sys);
    chk(s === 1'b1 && cd_n == 1 && in_standby === 1'b1, "addr end");
    $display("t_addr_only finished");
  endtask : t_addr_only

  task automatic t_write();
    m.header(s);
    m.byte_out(ADDR, 1'b1, s);
    chk(s === 1'b1, "addr nak");
    m.byte_out(8'h6C, 1'b1, s);
    chk(s === 1'b1 && cmd_reg === 8'h6C, "cmd");
    m.byte_out(8'hA5, 1'b0, s);
    m.gap();
    @(negedge clk_sys);
    chk(s === 1'b1 && ws_n == 1 && cd_n == 2 && in_standby === 1'b1, "write end");
    pop(9'h16C);
    pop(9'h0A5);
    $display("t_write finished");
  endtask : t_write

  task automatic t_cmd_end();
    m.header(s);
    m.byte_out(ADDR, 1'b1, s);
    m.byte_out(8'h6E, 1'b0, s);
    m.gap();
    @(negedge clk_sys);
    chk(s === 1'b0 && ws_n == 1 && in_standby === 1'b0 && rx_valid === 1'b0, "early end");
    m.standby();
    m.header(s);
    m.byte_out(ADDR, 1'b1, s);
    cmd_reject <= 1'b1;
    m.byte_out(8'h03, 1'b1, s);
    cmd_reject <= 1'b0;
    chk(s === 1'b0 && rx_valid === 1'b0, "rejected cmd");
    m.byte_out(8'h00, 1'b1, s);
    chk(s === 1'b0, "idle data");
    $display("t_cmd_end finished");
  endtask : t_cmd_end

  task automatic t_bad_addr();
    logic [7:0] bad [2] = '{8'h54, 8'h63};
    for (int i = 0; i < 2; i++)
    begin
      m.standby();
      m.header(s);
      m.byte_out(bad[i], 1'b1, s);
      chk(s === 1'b0, "foreign addr");
    end
    m.standby();
    m.header(s);
    m.gap();
    m.byte_out(ADDR, 1'b1, s);
    chk(s === 1'b0 && in_standby === 1'b0, "lost sync acked");
    $display("t_bad_addr finished");
  endtask : t_bad_addr

  task automatic t_fill();
    m.standby();
    m.header(s);
    m.byte_out(ADDR, 1'b1, s);
    m.byte_out(8'h6C, 1'b1, s);
    chk(s === 1'b1, "cmd nak");
    for (int i = 0; i < 7; i++)
    begin
      m.byte_out(8'h10 + 8'(i), 1'b1, s);
      chk(s === 1'b1, "data nak");
    end
    m.byte_out(8'hEE, 1'b1, s);
    chk(s === 1'b0, "full fifo ack");
    pop(9'h16C);
    for (int i = 0; i < 7; i++)
    begin
      pop({1'b0, 8'h10 + 8'(i)});
    end
    @(negedge clk_sys);
    chk(rx_valid === 1'b0, "fifo not empty");
    m.standby();
    $display("t_fill finished");
  endtask : t_fill

  initial
  begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_addr_only();
    t_write();
    t_cmd_end();
    t_bad_addr();
    t_fill();
    test_done();
  end

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
endmodule : sps_slave_tb_top
